/* File: hw/rcore_map.vh */
`ifndef RCORE_MAP_VH
`define RCORE_MAP_VH
// Datapath
`define RCORE_WIDTH 16
`define RCORE_NREGS 16
`define RCORE_IDX_W 4
// Dedicated register indices
`define RCORE_IDX_PC 4'h0
`define RCORE_IDX_SP 4'h1
`define RCORE_IDX_STATUS 4'h2
`define RCORE_IDX_CG 4'h3
// Source addressing modes (seven)
`define RCORE_SM_REG 3'h0
`define RCORE_SM_IDX 3'h1
`define RCORE_SM_SYM 3'h2
`define RCORE_SM_ABS 3'h3
`define RCORE_SM_IND 3'h4
`define RCORE_SM_INC 3'h5
`define RCORE_SM_IMM 3'h6
// Destination addressing modes (four)
`define RCORE_DM_REG 2'h0
`define RCORE_DM_IDX 2'h1
`define RCORE_DM_SYM 2'h2
`define RCORE_DM_ABS 2'h3
// Instruction formats
`define RCORE_FMT_DUAL 2'h0
`define RCORE_FMT_SINGLE 2'h1
`define RCORE_FMT_JUMP 2'h2
`define RCORE_NUM_INSNS 51
// Constant generator selector (As field 0..3)
`define RCORE_CG_AS_W 2
// Reset values
`define RCORE_RST_VAL 16'h0000
// Status register field positions
`define RCORE_STATUS_C 0
`define RCORE_STATUS_Z 1
`define RCORE_STATUS_N 2
`define RCORE_STATUS_V 8
`endif

/* File: hw/rcore_word_reg.v */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// One 16-bit storage word with byte write
// ****************************************
`include "rcore_map.vh"
module rcore_word_reg (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  // Write side
  input wire wr_en,
  input wire wr_byte,
  input wire [15:0] wr_data,
  // Stored word
  output reg [15:0] q
);
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= `RCORE_RST_VAL;
    else if (clk_en && wr_en)
    begin
      if (wr_byte)
        q <= {8'h00, wr_data[7:0]};
      else
        q <= wr_data;
    end
  end
endmodule // rcore_word_reg
`default_nettype wire

/* File: hw/rcore_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "rcore_map.vh"
// Behaviour
// - Datapath, registers and word operands are all sixteen bits wide.
// - Sixteen registers, indices 0..15; indices 4..15 are plain storage.
// - Indices 0..3 are program counter, stack pointer, status, constant generator.
// - Register-to-register operation completes in one clock cycle.
// - All non-flow operations run as register operations via addressing modes.
// - Seven source addressing modes, four destination addressing modes.
// - Fifty-one instructions in three encoding formats share the addressing modes.
// - Every operation takes word or byte operand; byte uses low eight bits.
// - Peripherals share data, address, control buses; outside jump format, any mode other than register, immediate or constant reaches them.
module rcore_core (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  // Operation request
  input wire op_valid,
  input wire [1:0] op_fmt,
  input wire [5:0] op_code,
  input wire op_byte,
  input wire [3:0] src_idx,
  input wire [2:0] src_mode,
  input wire [3:0] dst_idx,
  input wire [1:0] dst_mode,
  input wire [15:0] op_ext_src,
  input wire [15:0] op_ext_dst,
  input wire [15:0] alu_result,
  input wire [15:0] status_in,
  input wire status_wr,
  // Operand outputs
  output reg [15:0] src_operand,
  output reg [15:0] dst_operand,
  output wire op_done,
  output wire op_illegal,
  // Shared system bus
  output reg [15:0] bus_addr,
  output reg [15:0] bus_wdata,
  output reg bus_rd,
  output reg bus_wr,
  output reg bus_byte,
  input wire [15:0] bus_rdata,
  input wire bus_ready,
  // Register observation
  output wire [15:0] pc_value,
  output wire [15:0] sp_value,
  output wire [15:0] status_reg
);
  // ****************************************
  // Sequencer states
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_SRC = 2'b01;
  localparam ST_DRD = 2'b10;
  localparam ST_DWR = 2'b11;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] lat_dst_idx;
  reg [1:0] lat_dst_mode;
  reg [15:0] lat_dst_addr;
  reg lat_byte;

  // ****************************************
  // Register array
  // ****************************************
  wire [15:0] regs [0:15];
  reg [15:0] wr_en_vec;
  reg [15:0] wr_data;
  reg wr_byte;
  genvar gi;
  generate
    for (gi = 0; gi < `RCORE_NREGS; gi = gi + 1)
    begin : g_reg
      if (gi == 3)
      begin : g_cg
        assign regs[gi] = `RCORE_RST_VAL;
      end
      else
      begin : g_word
        rcore_word_reg u_word (
          .clock(clock),
          .rst_n(rst_n),
          .clk_en(clk_en),
          .wr_en(wr_en_vec[gi]),
          .wr_byte(wr_byte),
          .wr_data(wr_data),
          .q(regs[gi])
        );
      end
    end
  endgenerate

  assign pc_value = regs[`RCORE_IDX_PC];
  assign sp_value = regs[`RCORE_IDX_SP];
  assign status_reg = regs[`RCORE_IDX_STATUS];

  // ****************************************
  // Decode and constant generation
  // ****************************************
  wire is_jump = (op_fmt == `RCORE_FMT_JUMP);
  wire bad_fmt = (op_fmt == 2'h3);
  wire bad_code = (op_code >= 6'h33);
  wire bad_smode = (src_mode == 3'h7);
  assign op_illegal = op_valid && (bad_fmt || bad_code || bad_smode);

  // Constant source: index 3 with register, indexed or indirect style modes, index 2 with indirect style modes only
  reg cg_hit;
  reg [15:0] cg_val;
  always @*
  begin
    cg_hit = 1'b0;
    cg_val = 16'h0000;
    if (src_idx == `RCORE_IDX_CG)
    begin
      cg_hit = (src_mode == `RCORE_SM_REG) || (src_mode == `RCORE_SM_IDX) ||
        (src_mode == `RCORE_SM_IND) || (src_mode == `RCORE_SM_INC);
      case (src_mode)
        `RCORE_SM_REG: cg_val = 16'h0000;
        `RCORE_SM_IDX: cg_val = 16'h0001;
        `RCORE_SM_IND: cg_val = 16'h0002;
        default: cg_val = 16'hffff;
      endcase
    end
    else if (src_idx == `RCORE_IDX_STATUS)
    begin
      cg_hit = (src_mode == `RCORE_SM_IND) || (src_mode == `RCORE_SM_INC);
      cg_val = (src_mode == `RCORE_SM_IND) ? 16'h0004 : 16'h0008;
    end
  end

  // Source address per mode
  reg [15:0] src_addr;
  reg src_mem;
  always @*
  begin
    src_mem = (src_mode >= `RCORE_SM_IDX) && (src_mode <= `RCORE_SM_INC) && !cg_hit;
    case (src_mode)
      `RCORE_SM_IDX: src_addr = regs[src_idx] + op_ext_src;
      `RCORE_SM_SYM: src_addr = regs[`RCORE_IDX_PC] + op_ext_src;
      `RCORE_SM_ABS: src_addr = op_ext_src;
      default: src_addr = regs[src_idx];
    endcase
  end

  reg [15:0] dst_addr;
  reg dst_mem;
  always @*
  begin
    dst_mem = 1'b1;
    case (dst_mode)
      `RCORE_DM_IDX: dst_addr = regs[dst_idx] + op_ext_dst;
      `RCORE_DM_SYM: dst_addr = regs[`RCORE_IDX_PC] + op_ext_dst;
      `RCORE_DM_ABS: dst_addr = op_ext_dst;
      default:
      begin
        dst_addr = 16'h0000;
        dst_mem = 1'b0;
      end
    endcase
  end

  wire [15:0] src_reg_val = cg_hit ? cg_val :
    (src_mode == `RCORE_SM_IMM) ? op_ext_src : regs[src_idx];
  wire accept = op_valid && !op_illegal && (state == ST_IDLE) && clk_en;
  wire fast = accept && !src_mem && !dst_mem && !is_jump;
  wire [15:0] bus_mask = lat_byte ? 16'h00ff : 16'hffff;

  // ****************************************
  // Sequencer
  // ****************************************
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (accept && !is_jump)
        begin
          if (src_mem)
            next_state = ST_SRC;
          else if (dst_mem)
            next_state = ST_DRD;
        end
      ST_SRC: if (bus_ready) next_state = lat_dst_mode != `RCORE_DM_REG ? ST_DRD : ST_IDLE;
      ST_DRD: if (bus_ready) next_state = ST_DWR;
      ST_DWR: if (bus_ready) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign op_done = fast || (accept && is_jump) ||
    (clk_en && state == ST_SRC && bus_ready && lat_dst_mode == `RCORE_DM_REG) ||
    (clk_en && state == ST_DWR && bus_ready);

  // Register write steering
  always @*
  begin
    wr_en_vec = 16'h0000;
    wr_data = alu_result;
    wr_byte = op_byte;
    if (fast || (state == ST_SRC && bus_ready && lat_dst_mode == `RCORE_DM_REG))
    begin
      wr_en_vec[fast ? dst_idx : lat_dst_idx] = 1'b1;
      wr_byte = fast ? op_byte : lat_byte;
    end
    else if (accept && is_jump)
    begin
      wr_en_vec[`RCORE_IDX_PC] = 1'b1;
      wr_byte = 1'b0;
    end
    else if (accept && src_mem && src_mode == `RCORE_SM_INC)
    begin
      wr_en_vec[src_idx] = 1'b1;
      wr_data = regs[src_idx] + (op_byte ? 16'h0001 : 16'h0002);
      wr_byte = 1'b0;
    end
    else if (status_wr && clk_en)
    begin
      wr_en_vec[`RCORE_IDX_STATUS] = 1'b1;
      wr_data = status_in;
      wr_byte = 1'b0;
    end
    wr_en_vec[`RCORE_IDX_CG] = 1'b0;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      lat_dst_idx <= 4'h0;
      lat_dst_mode <= 2'h0;
      lat_dst_addr <= 16'h0000;
      lat_byte <= 1'b0;
      src_operand <= 16'h0000;
      dst_operand <= 16'h0000;
      bus_addr <= 16'h0000;
      bus_wdata <= 16'h0000;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      bus_byte <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      if (accept)
      begin
        lat_dst_idx <= dst_idx;
        lat_dst_mode <= dst_mode;
        lat_dst_addr <= dst_addr;
        lat_byte <= op_byte;
        src_operand <= op_byte ? {8'h00, src_reg_val[7:0]} : src_reg_val;
        dst_operand <= op_byte ? {8'h00, regs[dst_idx][7:0]} : regs[dst_idx];
        bus_byte <= op_byte;
        if (src_mem && !is_jump)
        begin
          bus_addr <= src_addr;
          bus_rd <= 1'b1;
        end
        else if (dst_mem && !is_jump)
        begin
          bus_addr <= dst_addr;
          bus_rd <= 1'b1;
        end
      end
      else if (state == ST_SRC && bus_ready)
      begin
        src_operand <= bus_rdata & bus_mask;
        if (lat_dst_mode != `RCORE_DM_REG)
          bus_addr <= lat_dst_addr;
        else
          bus_rd <= 1'b0;
      end
      else if (state == ST_DRD && bus_ready)
      begin
        dst_operand <= bus_rdata & bus_mask;
        bus_rd <= 1'b0;
        bus_wr <= 1'b1;
        bus_wdata <= alu_result & bus_mask;
      end
      else if (state == ST_DWR && bus_ready)
        bus_wr <= 1'b0;
    end
  end
endmodule // rcore_core
`default_nettype wire

/* File: tb/rcore_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rcore_bus_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus from core
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_byte,
  input wire logic slow,
  output logic [15:0] bus_rdata,
  output logic bus_ready
);
  logic [15:0] mem [0:255];
  logic [1:0] cnt;
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 2'h0;
      bus_ready <= 1'b0;
      bus_rdata <= 16'h5a5a;
    end
    else if (bus_ready || !(bus_rd || bus_wr) || (slow && cnt != 2'h3))
    begin
      // Data not valid here, so keep it moving
      cnt <= bus_ready ? 2'h0 : cnt + 2'h1;
      bus_ready <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end
    else
    begin
      // Any location answers a read or write
      bus_ready <= 1'b1;
      bus_rdata <= mem[bus_addr[8:1]];
      if (bus_wr)
        mem[bus_addr[8:1]] <= bus_byte ? {8'h00, bus_wdata[7:0]} : bus_wdata;
    end
  end
endmodule // rcore_bus_model
`default_nettype wire

/* File: tb/rcore_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rcore_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Request
  input wire logic op_valid,
  input wire logic [1:0] op_fmt,
  input wire logic [5:0] op_code,
  input wire logic [2:0] src_mode,
  input wire logic [1:0] dst_mode,
  input wire logic [15:0] alu_result,
  input wire logic [15:0] status_in,
  input wire logic status_wr,
  // Outputs
  input wire logic op_done,
  input wire logic op_illegal,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_ready,
  input wire logic [15:0] pc_value,
  input wire logic [15:0] status_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_illegal_fmt: assert property (op_valid && op_fmt == 2'h3 |-> op_illegal)
    else $error("bad format not flagged");
  a_illegal_code: assert property (op_valid && op_code > 6'h32 |-> op_illegal)
    else $error("bad code not flagged");
  a_illegal_mode: assert property (op_valid && src_mode == 3'h7 |-> op_illegal)
    else $error("bad mode not flagged");
  a_illegal_quiet: assert property (op_illegal && !bus_rd && !bus_wr |-> !op_done)
    else $error("ignored op completed");
  a_reg_single: assert property (clk_en && op_valid && !op_illegal && op_fmt == 2'h0
    && src_mode == 3'h0 && dst_mode == 2'h0 && !bus_rd && !bus_wr |-> op_done)
    else $error("reg op not done in one cycle");
  a_rd_holds: assert property (bus_rd && !bus_ready |=> bus_rd && $stable(bus_addr))
    else $error("read dropped early");
  a_wr_holds: assert property (bus_wr && !bus_ready |=> bus_wr && $stable(bus_wdata))
    else $error("write dropped early");
  a_status_load: assert property (clk_en && status_wr && !op_valid && !bus_rd && !bus_wr
    |=> status_reg == $past(status_in))
    else $error("status not loaded");
  a_jump_pc: assert property (op_valid && op_fmt == 2'h2 && op_done && !bus_rd && !bus_wr
    |=> pc_value == $past(alu_result))
    else $error("jump target not in pc");
endmodule // rcore_chk
bind rcore_core rcore_chk u_chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
  .op_valid(op_valid), .op_fmt(op_fmt), .op_code(op_code), .src_mode(src_mode),
  .dst_mode(dst_mode), .alu_result(alu_result), .status_in(status_in),
  .status_wr(status_wr), .op_done(op_done), .op_illegal(op_illegal),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
  .bus_ready(bus_ready), .pc_value(pc_value), .status_reg(status_reg));
`default_nettype wire

/* File: tb/risc_cpu_register_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module risc_cpu_register_core_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0, op_byte = 1'b0, status_wr = 1'b0, slow = 1'b0, clk_en = 1'b1;
  logic [1:0] op_fmt = 2'h0, dst_mode = 2'h0;
  logic [5:0] op_code = 6'h0;
  logic [3:0] src_idx = 4'h0, dst_idx = 4'h0;
  logic [2:0] src_mode = 3'h0;
  logic [15:0] op_ext = 16'h0, alu_result = 16'h0, status_in = 16'h0, v, a, dst_operand;
  logic [15:0] bus_rdata, src_operand, pc_value, sp_value, status_reg, bus_addr, bus_wdata;
  logic op_done, op_illegal, bus_rd, bus_wr, bus_byte, bus_ready, got;
  logic [31:0] lfsr = 32'h818e;
  logic [15:0] exp_reg [16];
  logic [15:0] cg_val [6] = '{16'h0, 16'h1, 16'h2, 16'hffff, 16'h4, 16'h8};
  logic [2:0] cg_mode [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h4, 3'h5};
  int fails = 0, checks_done = 0, cyc = 0, i;
  always #20 clock = ~clock;
  rcore_core uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .op_valid(op_valid),
    .op_fmt(op_fmt), .op_code(op_code), .op_byte(op_byte), .src_idx(src_idx),
    .src_mode(src_mode), .dst_idx(dst_idx), .dst_mode(dst_mode), .op_ext_src(op_ext),
    .op_ext_dst(op_ext), .alu_result(alu_result), .status_in(status_in),
    .status_wr(status_wr), .src_operand(src_operand), .dst_operand(dst_operand),
    .op_done(op_done),
    .op_illegal(op_illegal), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_byte(bus_byte), .bus_rdata(bus_rdata), .bus_ready(bus_ready),
    .pc_value(pc_value), .sp_value(sp_value), .status_reg(status_reg));
  rcore_bus_model u_bus (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_byte(bus_byte),
    .slow(slow), .bus_rdata(bus_rdata), .bus_ready(bus_ready));
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    next_rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [1:0] f, input logic [3:0] si, input logic [2:0] sm,
    input logic [3:0] di, input logic [1:0] dm, input logic [15:0] res, input logic b);
    int n;
    n = 0;
    @(posedge clock);
    op_valid <= 1'b1;
    op_fmt <= f;
    op_code <= 6'(lfsr[7:0] % 51);
    src_idx <= si;
    src_mode <= sm;
    dst_idx <= di;
    dst_mode <= dm;
    alu_result <= res;
    op_byte <= b;
    op_ext <= a;
    @(negedge clock);
    got = op_done;
    @(posedge clock);
    op_valid <= 1'b0;
    while (got !== 1'b1 && n < 30)
    begin
      @(negedge clock);
      got = op_done;
      n++;
    end
    chk({15'h0, got}, 16'h1);
    @(negedge clock);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(pc_value | sp_value | status_reg, 16'h0);
    $display("reset test done");
    for (i = 4; i < 16; i++)
    begin
      lfsr = next_rnd(lfsr);
      exp_reg[i] = lfsr[16] ? {8'h00, lfsr[7:0]} : lfsr[15:0];
      run(2'h0, 4'h4, 3'h0, 4'(i), 2'h0, lfsr[15:0], lfsr[16]);
    end
    for (i = 4; i < 16; i++)
    begin
      run(2'h0, 4'(i), 3'h0, 4'(i ^ 1), 2'h0, exp_reg[i ^ 1], 1'b0);
      chk(src_operand, exp_reg[i]);
      chk(dst_operand, exp_reg[i ^ 1]);
    end
    $display("register test done");
    for (i = 0; i < 6; i++)
    begin
      lfsr = next_rnd(lfsr);
      run(2'h0, (i < 4) ? 4'h3 : 4'h2, cg_mode[i], 4'h3, 2'h0, lfsr[15:0], 1'b0);
      chk(src_operand, cg_val[i]);
    end
    $display("constant test done");
    v = lfsr[31:16];
    run(2'h0, 4'h4, 3'h0, 4'h1, 2'h0, v, 1'b0);
    chk(sp_value, v);
    run(2'h2, 4'h4, 3'h0, 4'h0, 2'h0, ~v, 1'b0);
    chk(pc_value, ~v);
    @(posedge clock);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    op_fmt <= 2'h0;
    dst_idx <= 4'h1;
    @(negedge clock);
    chk({15'h0, op_done}, 16'h0);
    @(posedge clock);
    clk_en <= 1'b1;
    op_valid <= 1'b0;
    @(negedge clock);
    chk(sp_value, v);
    @(posedge clock);
    status_wr <= 1'b1;
    status_in <= v ^ 16'h0105;
    @(posedge clock);
    status_wr <= 1'b0;
    @(negedge clock);
    chk(status_reg, v ^ 16'h0105);
    $display("dedicated test done");
    for (i = 0; i < 2; i++)
    begin
      slow <= i[0];
      lfsr = next_rnd(lfsr);
      a = {7'h0, lfsr[8:1], 1'b0};
      run(2'h0, 4'h4, 3'h0, 4'h0, 2'h3, lfsr[31:16], 1'b0);
      run(2'h0, 4'h0, 3'h3, 4'h3, 2'h0, 16'h0, 1'b0);
      chk(src_operand, lfsr[31:16]);
      run(2'h0, 4'h4, 3'h0, 4'h6, 2'h0, a, 1'b0);
      run(2'h0, 4'h6, 3'h5, 4'h3, 2'h0, 16'h0, 1'b0);
      chk(src_operand, lfsr[31:16]);
      run(2'h0, 4'h6, 3'h0, 4'h3, 2'h0, 16'h0, 1'b0);
      chk(src_operand, a + 16'h0002);
      a = a - exp_reg[5];
      run(2'h0, 4'h5, 3'h1, 4'h3, 2'h0, 16'h0, 1'b0);
      chk(src_operand, lfsr[31:16]);
      run(2'h0, 4'h4, 3'h6, 4'h3, 2'h0, 16'h0, 1'b0);
      chk(src_operand, a);
    end
    $display("bus test done");
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(pc_value | sp_value | status_reg, 16'h0);
    $display("mid reset test done");
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock);
      op_valid <= 1'b1;
      op_fmt <= (i == 0) ? 2'h3 : 2'h0;
      op_code <= (i == 1) ? 6'h33 : 6'h0;
      src_mode <= (i == 2) ? 3'h7 : 3'h0;
      @(negedge clock);
      chk({14'h0, op_illegal, op_done}, 16'h2);
    end
    @(posedge clock);
    op_valid <= 1'b0;
    $display("illegal test done");
    end_of_test();
  end
endmodule // risc_cpu_register_core_tb_top
`default_nettype wire
